// >>> rtl/epa_top.sv
// Enclave page augment engine with its APB register file.
// Assumes an APB3 master on sys_clk; no other clock, and reset is the only other pin input.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module epa_top (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr
);
   import epa_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_CHECK, S_ZERO, S_META, S_VALID
   } epa_state_t;

   typedef struct packed {
      epa_state_t         state;
      logic [7:0]         leaf;
      logic [31:0]        pbp;
      logic [31:0]        tpp;
      logic [31:0]        ctlp;
      logic [31:0]        lin;
      logic [31:0]        src;
      logic [31:0]        sec;
      logic [31:0]        base;
      logic [31:0]        size;
      logic [15:0]        env;
      logic [31:0]        seg;
      logic [IDX_W-1:0]   sel;
      logic [11:0]        wsel;
      logic               busy;
      logic               done;
      logic               fault;
      logic               pf;
      epa_chk_t           chk;
      logic [31:0]        faddr;
      logic [WADDR_W-1:0] wcnt;
      logic [IDX_W-1:0]   t_idx;
      logic [IDX_W-1:0]   c_idx;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
   } epa_core_t;

   epa_core_t q, d;
   epa_mem_if mif ();

   // Address decode helpers, each used for several operands
   function automatic logic in_cache(input logic [31:0] a);
      in_cache = (a >= CACHE_BASE) && (a < CACHE_END);
   endfunction

   function automatic logic canon_ok(input logic [31:0] a);
      canon_ok = (&a[31:CANON_MSB]) || !(|a[31:CANON_MSB]);
   endfunction

   function automatic logic [IDX_W-1:0] page_of(input logic [31:0] a);
      page_of = a[12 +: IDX_W];
   endfunction

   // Environment fields
   logic [1:0] cpl;
   logic       mode64, prot, ctl_init, ctl_busy, tgt_use;
   logic [7:0] attr;
   assign cpl      = q.env[ENV_CPL_LSB +: 2];
   assign mode64   = q.env[ENV_MODE64];
   assign prot     = q.env[ENV_PROT];
   assign ctl_init = q.env[ENV_INIT];
   assign ctl_busy = q.env[ENV_CTL_BUSY];
   assign tgt_use  = q.env[ENV_TGT_USE];
   assign attr     = q.env[ENV_ATTR_LSB +: 8];

   epa_meta_tab u_meta (
      .sys_clk (sys_clk),
      .reset   (reset),
      .mp      (mif.meta)
   );

   epa_page_ram u_ram (
      .sys_clk (sys_clk),
      .pp      (mif.page)
   );

   // Read ports follow the operand registers directly
   assign mif.tgt_idx  = page_of(q.tpp);
   assign mif.ctl_idx  = page_of(q.ctlp);
   assign mif.sel_idx  = q.sel;
   assign mif.pg_rpage = q.wsel[11:10];
   assign mif.pg_rword = q.wsel[9:0];

   // Pending pages are not reachable until accepted
   logic acc_ok;
   assign acc_ok = mif.sel_ent.valid && !mif.sel_ent.pending;

   // Check chain: first failure wins, later ones are never seen
   logic     ck_fault, ck_pf;
   epa_chk_t ck_id;
   logic [31:0] ck_addr;
   logic [32:0] lim;
   assign lim = {1'b0, q.base} + {1'b0, q.size};

   always_comb begin
      ck_fault = 1'b1;
      ck_pf    = 1'b0;
      ck_addr  = PROT_CODE;
      ck_id    = CK_NONE;
      if (q.leaf != LEAF_AUGMENT || cpl != CPL_KERNEL) begin
         ck_id = CK_LEAF;
      end else if (!mode64 && prot &&
                   (q.pbp > q.seg || q.tpp > q.seg)) begin
         ck_id = CK_SEG;
      end else if (mode64 && !(canon_ok(q.pbp) && canon_ok(q.tpp) &&
                   canon_ok(q.ctlp) && canon_ok(q.lin))) begin
         ck_id = CK_CANON;
      end else if (|(q.pbp & PBP_ALIGN_MASK)) begin
         ck_id = CK_PBP_ALIGN;
      end else if (|(q.tpp & PAGE_MASK)) begin
         ck_id = CK_TPP_ALIGN;
      end else if (!in_cache(q.tpp)) begin
         ck_id   = CK_TPP_RANGE;
         ck_pf   = 1'b1;
         ck_addr = q.tpp;
      end else if (|(q.ctlp & PAGE_MASK) || |(q.lin & PAGE_MASK)) begin
         ck_id = CK_OPND_ALIGN;
      end else if (q.src != 32'h0 || q.sec != 32'h0) begin
         ck_id = CK_ZERO_FIELDS;
      end else if (|(attr & ~ATTR_SUPPORTED)) begin
         ck_id = CK_ATTR;
      end else if (!in_cache(q.ctlp)) begin
         ck_id   = CK_CTL_RANGE;
         ck_pf   = 1'b1;
         ck_addr = q.ctlp;
      end else if (tgt_use) begin
         ck_id = CK_TGT_INUSE;
      end else if (mif.tgt_ent.valid) begin
         ck_id   = CK_TGT_VALID;
         ck_pf   = 1'b1;
         ck_addr = q.tpp;
      end else if (ctl_busy) begin
         ck_id = CK_CTL_BUSY;
      end else if (!mif.ctl_ent.valid ||
                   mif.ctl_ent.pt != PT_CONTROL) begin
         ck_id   = CK_CTL_TYPE;
         ck_pf   = 1'b1;
         ck_addr = q.ctlp;
      end else if (!ctl_init) begin
         ck_id = CK_NOT_INIT;
      end else if ({1'b0, q.lin} < {1'b0, q.base} ||
                   {1'b0, q.lin} >= lim) begin
         ck_id = CK_LIN_RANGE;
      end else begin
         ck_fault = 1'b0;
      end
   end

   // Register read mux; unmapped offsets answer with an error
   logic [31:0] rd_val;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0;
      case (paddr)
         OFF_LEAF:  rd_val = {24'h0, q.leaf};
         OFF_PBP:   rd_val = q.pbp;
         OFF_TPP:   rd_val = q.tpp;
         OFF_CTLP:  rd_val = q.ctlp;
         OFF_LIN:   rd_val = q.lin;
         OFF_SRC:   rd_val = q.src;
         OFF_SEC:   rd_val = q.sec;
         OFF_BASE:  rd_val = q.base;
         OFF_SIZE:  rd_val = q.size;
         OFF_ENV:   rd_val = {16'h0, q.env};
         OFF_SEG:   rd_val = q.seg;
         OFF_CMD:   rd_val = 32'h0;
         OFF_STAT:  rd_val = {19'h0, q.chk, 4'h0,
                             q.pf, q.fault, q.done, q.busy};
         OFF_FADDR: rd_val = q.faddr;
         OFF_MSEL:  rd_val = {30'h0, q.sel};
         OFF_MDATA: rd_val = mif.sel_ent;
         OFF_ACC:   rd_val = {31'h0, acc_ok};
         OFF_WSEL:  rd_val = {20'h0, q.wsel};
         OFF_WDATA: rd_val = mif.pg_rdata;
         default:   rd_hit = 1'b0;
      endcase
   end

   logic setup, wr_acc, idle;
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && q.pready && pwrite;
   assign idle   = (q.state == S_IDLE);

   // Next state: bus slave, register writes and the engine
   always_comb begin
      d            = q;
      d.pready     = 1'b0;
      d.pslverr    = 1'b0;
      mif.mwr_en   = 1'b0;
      mif.mwr_idx  = q.t_idx;
      mif.mwr_ent  = '0;
      mif.pg_wr_en = 1'b0;
      mif.pg_page  = q.t_idx;
      mif.pg_word  = q.wcnt;
      mif.pg_wdata = 32'h0;
      // Zero-wait slave: answer in the first access cycle
      if (setup) begin
         d.pready  = 1'b1;
         d.pslverr = !rd_hit;
         d.prdata  = pwrite ? 32'h0 : rd_val;
      end
      // Operands are frozen while the engine runs
      if (wr_acc && idle) begin
         case (paddr)
            OFF_LEAF:  d.leaf = pwdata[7:0];
            OFF_PBP:   d.pbp  = pwdata;
            OFF_TPP:   d.tpp  = pwdata;
            OFF_CTLP:  d.ctlp = pwdata;
            OFF_LIN:   d.lin  = pwdata;
            OFF_SRC:   d.src  = pwdata;
            OFF_SEC:   d.sec  = pwdata;
            OFF_BASE:  d.base = pwdata;
            OFF_SIZE:  d.size = pwdata;
            OFF_ENV:   d.env  = pwdata[15:0];
            OFF_SEG:   d.seg  = pwdata;
            OFF_MSEL:  d.sel  = pwdata[IDX_W-1:0];
            OFF_WSEL:  d.wsel = pwdata[11:0];
            OFF_MDATA: begin
               mif.mwr_en  = 1'b1;
               mif.mwr_idx = q.sel;
               mif.mwr_ent = pwdata;
            end
            OFF_WDATA: begin
               mif.pg_wr_en = 1'b1;
               mif.pg_page  = q.wsel[11:10];
               mif.pg_word  = q.wsel[9:0];
               mif.pg_wdata = pwdata;
            end
            OFF_CMD: begin
               if (pwdata[CMD_ISSUE]) begin
                  d.state = S_CHECK;
                  d.busy  = 1'b1;
                  d.done  = 1'b0;
                  d.fault = 1'b0;
                  d.pf    = 1'b0;
                  d.chk   = CK_NONE;
                  d.faddr = PROT_CODE;
               end else if (pwdata[CMD_ACCEPT] &&
                            mif.sel_ent.valid &&
                            mif.sel_ent.pending) begin
                  mif.mwr_en          = 1'b1;
                  mif.mwr_idx         = q.sel;
                  mif.mwr_ent         = mif.sel_ent;
                  mif.mwr_ent.pending = 1'b0;
               end
            end
            default: ;
         endcase
      end
      case (q.state)
         S_IDLE: ;
         // a fault ends here with nothing written
         S_CHECK: begin
            if (ck_fault) begin
               d.state = S_IDLE;
               d.busy  = 1'b0;
               d.done  = 1'b1;
               d.fault = 1'b1;
               d.pf    = ck_pf;
               d.chk   = ck_id;
               d.faddr = ck_addr;
            end else begin
               d.state = S_ZERO;
               d.t_idx = page_of(q.tpp);
               d.c_idx = page_of(q.ctlp);
               d.wcnt  = '0;
            end
         end
         // clear every word of the page
         S_ZERO: begin
            mif.pg_wr_en = 1'b1;
            d.wcnt       = q.wcnt + 1'b1;
            if (q.wcnt == WADDR_W'(WORDS - 1)) begin
               d.state = S_META;
            end
         end
         S_META: begin
            mif.mwr_en           = 1'b1;
            mif.mwr_ent.rd       = 1'b1;
            mif.mwr_ent.wr       = 1'b1;
            mif.mwr_ent.pt       = PT_REGULAR;
            mif.mwr_ent.pending  = 1'b1;
            mif.mwr_ent.lin_page = q.lin[31:12];
            mif.mwr_ent.owner    = q.c_idx;
            d.state              = S_VALID;
         end
         S_VALID: begin
            mif.mwr_en        = 1'b1;
            mif.mwr_ent       = mif.tgt_ent;
            mif.mwr_ent.valid = 1'b1;
            d.state           = S_IDLE;
            d.busy            = 1'b0;
            d.done            = 1'b1;
         end
         default: d.state = S_IDLE;
      endcase
   end

   // Single state register for the whole core
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         q       <= '0;
         q.state <= S_IDLE;
         q.leaf  <= LEAF_RST;
         q.env   <= ENV_RST;
         q.seg   <= SEG_RST;
         q.chk   <= CK_NONE;
      end else begin
         q <= d;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_leaf_refused: assert property (
      q.state == S_CHECK && (q.leaf != LEAF_AUGMENT || cpl != CPL_KERNEL)
      |=> q.fault && !q.pf && q.chk == CK_LEAF && q.state == S_IDLE)
      else $error("wrong leaf was not refused");
   a_pbp_align: assert property (
      q.state == S_CHECK && |(q.pbp & PBP_ALIGN_MASK)
      |=> q.fault && q.chk <= CK_PBP_ALIGN && q.faddr == PROT_CODE)
      else $error("misaligned parameter pointer passed");
   a_tpp_align: assert property (
      q.state == S_CHECK && |(q.tpp & PAGE_MASK)
      |=> q.fault && q.chk <= CK_TPP_ALIGN)
      else $error("misaligned target pointer passed");
   a_tpp_range: assert property (
      q.state == S_CHECK && !in_cache(q.tpp)
      |=> q.fault && (q.chk < CK_TPP_RANGE ||
                      (q.pf && q.faddr == $past(q.tpp))))
      else $error("target outside cache not reported");
   a_zero_fields: assert property (
      q.state == S_CHECK && (q.src != 32'h0 || q.sec != 32'h0)
      |=> q.fault && q.chk <= CK_ZERO_FIELDS)
      else $error("nonzero source or security field passed");
   a_tgt_valid: assert property (
      q.state == S_CHECK && mif.tgt_ent.valid
      |=> q.fault && q.chk <= CK_TGT_VALID)
      else $error("valid target page overwritten");
   a_not_init: assert property (
      q.state == S_CHECK && !ctl_init
      |=> q.fault && q.chk <= CK_NOT_INIT &&
          (q.chk != CK_NOT_INIT || !q.pf))
      else $error("uninitialized enclave accepted");
   a_seg_limit: assert property (
      q.state == S_CHECK && !mode64 && prot && q.pbp > q.seg
      |=> q.fault && q.chk <= CK_SEG)
      else $error("segment limit not enforced");
   a_zero_data: assert property (
      q.state == S_ZERO |-> mif.pg_wr_en && mif.pg_wdata == 32'h0 &&
      mif.pg_word == q.wcnt && mif.pg_page == q.t_idx)
      else $error("page clear wrote wrong data or place");
   a_zero_len: assert property (
      q.state == S_ZERO && q.wcnt == WADDR_W'(WORDS - 1)
      |=> q.state == S_META ##1 q.state == S_VALID)
      else $error("page clear length wrong");
   a_entry_fields: assert property (
      q.state == S_META |-> mif.mwr_en && !mif.mwr_ent.valid &&
      mif.mwr_ent.rd && mif.mwr_ent.wr && !mif.mwr_ent.ex &&
      mif.mwr_ent.pt == PT_REGULAR && mif.mwr_ent.pending &&
      !mif.mwr_ent.blocked && !mif.mwr_ent.change_marker_flag &&
      !mif.mwr_ent.restriction_wait_flag &&
      mif.mwr_ent.lin_page == q.lin[31:12])
      else $error("entry fields wrong");
   a_owner_link: assert property (
      q.state == S_META |-> mif.mwr_ent.owner == page_of(q.ctlp))
      else $error("owner link wrong");
   a_valid_last: assert property (
      mif.mwr_en && mif.mwr_ent.valid && !idle
      |-> $past(q.state) == S_META && $past(mif.mwr_idx) == mif.mwr_idx)
      else $error("valid set before fields");
   a_pending_deny: assert property (
      setup && !pwrite && paddr == OFF_ACC && mif.sel_ent.pending
      |=> q.prdata[0] == 1'b0)
      else $error("pending page reported accessible");
   a_fault_clean: assert property (
      q.state == S_CHECK && ck_fault
      |=> !(mif.pg_wr_en || mif.mwr_en) [*2])
      else $error("faulting operation wrote state");

   c_success: cover property (q.state == S_VALID ##1 q.done);
   c_page_fault: cover property (q.state == S_CHECK && ck_pf);
   c_gp_fault: cover property (q.state == S_CHECK && ck_fault && !ck_pf);
   c_accept: cover property (wr_acc && paddr == OFF_CMD && mif.mwr_en);
endmodule

// >>> pkg/epa_pkg.sv
// Constants and types for the enclave page augment block.
// Assumes one 200 MHz clock and an APB master with 32-bit data.
// What this block does
// - Leaf 0Dh, privilege 0 only, else refused
// - Parameter pointer misaligned to 32 bytes: protection fault
// - Target pointer misaligned to 4 KB: protection fault
// - Target outside page cache: page fault, target
// - Control pointer or linear address misaligned: fault
// - Source and security fields must be zero
// - Control page outside, invalid or mistyped: page fault
// - Target page in use elsewhere: protection fault
// - Target entry already valid: page fault
// - Control page held by another thread: protection fault
// - Enclave not initialized: protection fault
// - Linear address outside enclave range: protection fault
// - Zero all 32768 bits of target page
// - Entry gets rw, regular, pending, linear address
// - Entry records owning control page link
// - Valid bit written last of all
// - Pending page denied until accept completes
// - Protected mode: parameter or target pointer beyond segment limit faults
// - 64-bit mode: non-canonical operand faults
// - Unsupported security attributes requested: fault
package epa_pkg;

   // Geometry of the protected page cache
   localparam int          PAGES      = 4;
   localparam int          IDX_W      = 2;
   localparam int          WORDS      = 1024;
   localparam int          WADDR_W    = 10;
   localparam int          CANON_MSB  = 23;
   localparam logic [31:0] CACHE_BASE = 32'h0010_0000;
   localparam logic [31:0] CACHE_END  = 32'h0010_4000;

   // Operation selection and operand checks
   localparam logic [7:0]  LEAF_AUGMENT   = 8'h0d;
   localparam logic [1:0]  CPL_KERNEL     = 2'h0;
   localparam logic [31:0] PBP_ALIGN_MASK = 32'h0000_001f;
   localparam logic [31:0] PAGE_MASK      = 32'h0000_0fff;
   localparam logic [7:0]  ATTR_SUPPORTED = 8'h00;
   localparam logic [31:0] PROT_CODE      = 32'h0000_0000;
   localparam logic [1:0]  PT_CONTROL     = 2'h1;
   localparam logic [1:0]  PT_REGULAR     = 2'h2;

   // Register byte offsets
   localparam logic [7:0] OFF_LEAF  = 8'h00;
   localparam logic [7:0] OFF_PBP   = 8'h04;
   localparam logic [7:0] OFF_TPP   = 8'h08;
   localparam logic [7:0] OFF_CTLP  = 8'h0c;
   localparam logic [7:0] OFF_LIN   = 8'h10;
   localparam logic [7:0] OFF_SRC   = 8'h14;
   localparam logic [7:0] OFF_SEC   = 8'h18;
   localparam logic [7:0] OFF_BASE  = 8'h1c;
   localparam logic [7:0] OFF_SIZE  = 8'h20;
   localparam logic [7:0] OFF_ENV   = 8'h24;
   localparam logic [7:0] OFF_SEG   = 8'h28;
   localparam logic [7:0] OFF_CMD   = 8'h2c;
   localparam logic [7:0] OFF_STAT  = 8'h30;
   localparam logic [7:0] OFF_FADDR = 8'h34;
   localparam logic [7:0] OFF_MSEL  = 8'h38;
   localparam logic [7:0] OFF_MDATA = 8'h3c;
   localparam logic [7:0] OFF_ACC   = 8'h40;
   localparam logic [7:0] OFF_WSEL  = 8'h44;
   localparam logic [7:0] OFF_WDATA = 8'h48;

   // Field positions
   localparam int ENV_CPL_LSB  = 0;
   localparam int ENV_MODE64   = 2;
   localparam int ENV_PROT     = 3;
   localparam int ENV_INIT     = 4;
   localparam int ENV_CTL_BUSY = 5;
   localparam int ENV_TGT_USE  = 6;
   localparam int ENV_ATTR_LSB = 8;
   localparam int CMD_ISSUE    = 0;
   localparam int CMD_ACCEPT   = 1;

   // Reset values
   localparam logic [7:0]  LEAF_RST = 8'h00;
   localparam logic [15:0] ENV_RST  = 16'h0000;
   localparam logic [31:0] SEG_RST  = 32'hffff_ffff;

   // One page metadata entry, exactly one word
   typedef struct packed {
      logic             valid;
      logic             rd;
      logic             wr;
      logic             ex;
      logic [1:0]       pt;
      logic             blocked;
      logic             pending;
      logic             change_marker_flag;
      logic             restriction_wait_flag;
      logic [IDX_W-1:0] owner;
      logic [19:0]      lin_page;
   } epa_ent_t;

   // Which check stopped the operation, in evaluation order
   typedef enum logic [4:0] {
      CK_NONE, CK_LEAF, CK_SEG, CK_CANON, CK_PBP_ALIGN, CK_TPP_ALIGN,
      CK_TPP_RANGE, CK_OPND_ALIGN, CK_ZERO_FIELDS, CK_ATTR,
      CK_CTL_RANGE, CK_TGT_INUSE, CK_TGT_VALID, CK_CTL_BUSY,
      CK_CTL_TYPE, CK_NOT_INIT, CK_LIN_RANGE
   } epa_chk_t;

endpackage

// >>> pkg/epa_mem_if.sv
// Carrier between the control core, the metadata map and page store.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface epa_mem_if;
   import epa_pkg::*;
   logic [IDX_W-1:0]   tgt_idx, ctl_idx, sel_idx, mwr_idx;
   epa_ent_t           tgt_ent, ctl_ent, sel_ent, mwr_ent;
   logic               mwr_en;
   logic               pg_wr_en;
   logic [IDX_W-1:0]   pg_page, pg_rpage;
   logic [WADDR_W-1:0] pg_word, pg_rword;
   logic [31:0]        pg_wdata, pg_rdata;

   modport core (output tgt_idx, ctl_idx, sel_idx, mwr_idx, mwr_ent,
                 mwr_en, pg_wr_en, pg_page, pg_word, pg_wdata,
                 pg_rpage, pg_rword,
                 input  tgt_ent, ctl_ent, sel_ent, pg_rdata);
   modport meta (input  tgt_idx, ctl_idx, sel_idx, mwr_idx, mwr_ent,
                 mwr_en,
                 output tgt_ent, ctl_ent, sel_ent);
   modport page (input  pg_wr_en, pg_page, pg_word, pg_wdata,
                 pg_rpage, pg_rword,
                 output pg_rdata);
endinterface

// >>> rtl/epa_meta_tab.sv
// Page metadata map: one entry per protected cache page.
// Assumes a single writer, the control core, on the same clock.
`timescale 1ns/1ps
module epa_meta_tab (
   input wire logic sys_clk,
   input wire logic reset,
   epa_mem_if.meta  mp
);
   import epa_pkg::*;

   epa_ent_t tab [PAGES];

   // Entries come out of reset invalid so no page is reachable
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < PAGES; i++) begin
            tab[i] <= '0;
         end
      end else if (mp.mwr_en) begin
         tab[mp.mwr_idx] <= mp.mwr_ent;
      end
   end

   // Three read ports, combinational
   assign mp.tgt_ent = tab[mp.tgt_idx];
   assign mp.ctl_ent = tab[mp.ctl_idx];
   assign mp.sel_ent = tab[mp.sel_idx];
endmodule

// >>> rtl/epa_page_ram.sv
// Page store of the protected cache, one word per address.
// Assumes writes only from the control core; no reset on contents.
`timescale 1ns/1ps
module epa_page_ram (
   input wire logic sys_clk,
   epa_mem_if.page  pp
);
   import epa_pkg::*;

   logic [31:0] mem [PAGES*WORDS];

   // Single write port; contents are undefined until written
   always_ff @(posedge sys_clk) begin
      if (pp.pg_wr_en) begin
         mem[{pp.pg_page, pp.pg_word}] <= pp.pg_wdata;
      end
   end

   // Asynchronous read for the register window
   assign pp.pg_rdata = mem[{pp.pg_rpage, pp.pg_rword}];
endmodule

// >>> tb/epa_tb.sv
// Bench for the page augment engine: APB driver, read monitor, checks.
// Assumes epa_top answers APB with no wait states on sys_clk.
`timescale 1ns/1ps
module tb;
   import epa_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rv;
   logic        pready, pslverr;
   logic [31:0] lf = 32'hd1fd;
   logic [34:0] expq[$];
   logic [34:0] e;
   int          err_total = 0;
   int          checked = 0;
   int          cyc = 0;
   // Known good operand set, one register per entry
   logic [39:0] cfg[11] = '{{OFF_LEAF, 32'hd}, {OFF_PBP, 32'h20},
      {OFF_TPP, 32'h101000}, {OFF_CTLP, 32'h103000}, {OFF_LIN, 32'h5000},
      {OFF_SRC, 32'h0}, {OFF_SEC, 32'h0}, {OFF_BASE, 32'h4000},
      {OFF_SIZE, 32'h2000}, {OFF_ENV, 32'h18}, {OFF_SEG, SEG_RST}};
   // One bad operand each: register, value, expected status
   logic [55:0] flt[17] = '{
      {OFF_LEAF, 32'hc, 16'h106}, {OFF_ENV, 32'h13, 16'h106}, // leaf
      {OFF_SEG, 32'h1f, 16'h206},                             // limit
      {OFF_PBP, 32'h24, 16'h406},                             // align
      {OFF_TPP, 32'h101004, 16'h506},                         // align
      {OFF_TPP, 32'h200000, 16'h60e},                         // range
      {OFF_LIN, 32'h5004, 16'h706},                           // align
      {OFF_SRC, 32'h1000, 16'h806}, {OFF_SEC, 32'h40, 16'h806}, // zero
      {OFF_ENV, 32'h110, 16'h906},                            // attr
      {OFF_CTLP, 32'h200000, 16'ha0e}, {OFF_CTLP, 32'h102000, 16'he0e},
      {OFF_ENV, 32'h50, 16'hb06},                             // in use
      {OFF_ENV, 32'h30, 16'hd06},                             // held
      {OFF_ENV, 32'h0, 16'hf06},                              // init
      {OFF_LIN, 32'h6000, 16'h1006}, {OFF_LIN, 32'h3000, 16'h1006}};

   epa_top dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   always #2.5 sys_clk = ~sys_clk;

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Compare one observed value, count it either way
   task automatic chk(input string n, input logic [31:0] x, y);
      checked++;
      if (y !== x) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, x, y);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // APB master: request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   // Reads note their expectation; kind bit1 error, bit0 data
   task automatic rd(input logic [7:0] a, input logic [1:0] k,
                     input logic [32:0] x);
      expq.push_back({k, x});
      xfer(1'b0, a, 32'h0);
   endtask
   // Start the operation, poll until idle; no fixed latency assumed
   task automatic issue();
      wr(OFF_CMD, 32'h1);
      do rd(OFF_STAT, 2'h0, 33'h0); while (rv[0] !== 1'b0);
   endtask

   // Read monitor: oldest note against each read answer
   always @(posedge sys_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         e = expq.pop_front();
         if (e[33])
            chk("prdata", e[31:0], prdata);
         if (e[34])
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      end
   end

   // Hang guard, well above the longest expected run
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      rd(OFF_SEG, 2'h3, SEG_RST);
      rd(OFF_STAT, 2'h3, 33'h0);
      rd(8'h4c, 2'h2, 33'h1_0000_0000);
      $display("test reset and map done");
      // Control page at index 3, a marked word in the target page
      wr(OFF_MSEL, 32'h3);
      wr(OFF_MDATA, 32'h8400_0000);
      lf = nxt(lf) | 32'h1;
      wr(OFF_WSEL, 32'h7ff);
      wr(OFF_WDATA, lf);
      foreach (flt[i]) begin
         foreach (cfg[j]) wr(cfg[j][39:32], cfg[j][31:0]);
         wr(flt[i][55:48], flt[i][47:16]);
         issue();
         rd(OFF_STAT, 2'h3, {17'h0, flt[i][15:0]}); // first fault
         rd(OFF_FADDR, 2'h3, flt[i][3] ? flt[i][47:16] : 32'h0); // addr
      end
      wr(OFF_ENV, 32'h14);
      wr(OFF_LIN, 32'h0080_5000);
      issue();
      rd(OFF_STAT, 2'h3, 33'h306); // canonical
      rd(OFF_WDATA, 2'h3, lf); // page intact
      $display("test faults done");
      foreach (cfg[j]) wr(cfg[j][39:32], cfg[j][31:0]);
      issue();
      rd(OFF_STAT, 2'h3, 33'h2); // success
      rd(OFF_WDATA, 2'h3, 33'h0); // last word zero
      wr(OFF_WSEL, 32'h400);
      rd(OFF_WDATA, 2'h3, 33'h0); // first word zero
      wr(OFF_MSEL, 32'h1);
      rd(OFF_MDATA, 2'h3, 32'he930_0005); // entry
      rd(OFF_ACC, 2'h3, 33'h0); // denied
      issue();
      rd(OFF_STAT, 2'h3, 33'hc0e); // already valid
      rd(OFF_FADDR, 2'h3, 32'h101000); // target address
      wr(OFF_CMD, 32'h2);
      rd(OFF_ACC, 2'h3, 33'h1); // accepted
      $display("test augment and accept done");
      complete_run();
   end
endmodule
